// ---- tmz_params.svh ----
// Purpose: offsets, field positions, reset values and timing counts for timer0
// Assumes: 9-bit file register address, four phase clocks per instruction
// Notes: definitions only
`ifndef TMZ_PARAMS_SVH
`define TMZ_PARAMS_SVH

// ----------------------------------------
// register addresses, with bank mirrors
// ----------------------------------------
`define TMZ_ADDR_COUNT_A 9'h001
`define TMZ_ADDR_COUNT_B 9'h101
`define TMZ_ADDR_INTC_A 9'h00b
`define TMZ_ADDR_INTC_B 9'h08b
`define TMZ_ADDR_INTC_C 9'h10b
`define TMZ_ADDR_INTC_D 9'h18b
`define TMZ_ADDR_OPT_A 9'h081
`define TMZ_ADDR_OPT_B 9'h181
`define TMZ_ADDR_DIR 9'h085

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define TMZ_INTC_IRQ_EN_BIT 5
`define TMZ_INTC_FLAG_BIT 2
`define TMZ_RST_COUNT 8'h00
`define TMZ_RST_INTC 8'h00
`define TMZ_RST_OPTION 8'hff
`define TMZ_RST_DIR 6'h3f

// ----------------------------------------
// phase clocks: samples taken on the second and fourth
// ----------------------------------------
`define TMZ_PHASE_Q2 2'h1
`define TMZ_PHASE_Q4 2'h3
`endif

// ---- tmz_pin_source.sv ----
// Purpose: external clock source model driving the timer pin
// Assumes: pulses are at least 4 clk high and 4 clk low
// Notes: pin rests low between bursts, it is not a free running clock
`timescale 1ns/1ps

module tmz_pin_source (
    // clock
    input wire logic clk,
    // pin
    output logic pin
);
    initial pin = 1'b0;

    // ----------------------------------------
    // burst of full pulses
    // ----------------------------------------
    // wide pulses so no edge can be lost in synchronisation
    task automatic pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            pin <= 1'b1;
            repeat (4) @(posedge clk);
            pin <= 1'b0;
        end
        repeat (8) @(posedge clk);
    endtask
endmodule

// ---- tmz_pkg.sv ----
// Purpose: shared types for the timer0 block
// Assumes: nothing beyond the params header
// Notes: option bit order follows the register, bit 7 first
package tmz_pkg;
    typedef struct packed {
        logic pullup_off;
        logic int_edge;
        logic clock_source_select;
        logic source_edge_select;
        logic prescaler_assign_bit;
        logic [2:0] prescale_ratio_field;
    } tmz_option_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [8:0] addr;
        logic [7:0] wdata;
    } tmz_reg_req_type;

    typedef enum logic [2:0] {
        TMZ_SEL_NONE,
        TMZ_SEL_COUNT,
        TMZ_SEL_INTC,
        TMZ_SEL_OPTION,
        TMZ_SEL_DIR
    } tmz_sel_type;
endpackage

// ---- tmz_timer0.sv ----
// Purpose: 8-bit timer0 with one 8-bit prescaler shared with the watchdog
// Assumes: clk is the oscillator, four clk per instruction cycle (Q1..Q4)
// Notes: register bus is the core's file register access, read data next cycle
// Contract
// - no prescaler: pin sampled on Q2, Q4
// - prescaler divides pin, symmetric output
// - timer increments after synchronisation latency
// - one counter, timer or watchdog, never both
// - option low nibble sets assignment and ratio
// - bit 3 set means watchdog, clear timer
// - timer count write clears prescaler when it is assigned to the timer
// - watchdog clear clears prescaler when assigned
// - prescaler count not software visible
// - count write keeps assignment and ratio
// - assignment changeable any time while running
`timescale 1ns/1ps
`include "tmz_params.svh"

module tmz_timer0
    import tmz_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // file register access
    input tmz_reg_req_type reg_req,
    output logic [7:0] reg_rdata,
    // pins and core events
    input wire logic timer_ext_clock_pin,
    input wire logic watchdog_clear_instr,
    input wire logic watchdog_tick,
    // results
    output logic watchdog_timeout,
    output logic timer_irq,
    output logic [5:0] porta_direction
);

    // ----------------------------------------
    // register decode
    // ----------------------------------------
    function automatic tmz_sel_type reg_select(input logic [8:0] addr);
        case (addr)
            `TMZ_ADDR_COUNT_A, `TMZ_ADDR_COUNT_B: reg_select = TMZ_SEL_COUNT;
            `TMZ_ADDR_INTC_A, `TMZ_ADDR_INTC_B,
            `TMZ_ADDR_INTC_C, `TMZ_ADDR_INTC_D: reg_select = TMZ_SEL_INTC;
            `TMZ_ADDR_OPT_A, `TMZ_ADDR_OPT_B: reg_select = TMZ_SEL_OPTION;
            `TMZ_ADDR_DIR: reg_select = TMZ_SEL_DIR;
            default: reg_select = TMZ_SEL_NONE;
        endcase
    endfunction

    function automatic logic [7:0] ratio_mask(input logic [2:0] ratio);
        ratio_mask = 8'((9'h001 << ratio) - 9'h001);
    endfunction

    tmz_sel_type wr_sel;
    logic count_wr;
    logic intc_wr;
    logic option_wr;
    tmz_option_type option;
    logic [7:0] timer0_count;
    logic [7:0] interrupt_control;
    logic [7:0] pre_cnt;
    logic [7:0] next_pre_cnt;
    logic [1:0] phase;
    logic sample_en;
    logic src_level;
    logic src_prev;
    logic src_rise;
    logic timer_level;
    logic sync_a;
    logic sync_b;
    logic t0_inc;
    logic t0_roll;
    logic pre_clear;
    logic wdt_hit;

    assign wr_sel = reg_select(reg_req.addr);
    assign count_wr = reg_req.wr && (wr_sel == TMZ_SEL_COUNT);
    assign intc_wr = reg_req.wr && (wr_sel == TMZ_SEL_INTC);
    assign option_wr = reg_req.wr && (wr_sel == TMZ_SEL_OPTION);

    // ----------------------------------------
    // phase clocks
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    assign sample_en = (phase == `TMZ_PHASE_Q2) || (phase == `TMZ_PHASE_Q4);

    // ----------------------------------------
    // count source: instruction clock or pin, edge chosen by xor
    // ----------------------------------------
    assign src_level = option.clock_source_select ?
        (timer_ext_clock_pin ^ option.source_edge_select) : phase[1];
    assign src_rise = src_level && !src_prev;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            src_prev <= 1'b1; // reset option turns an idle low pin into a high level
        end else begin
            src_prev <= src_level;
        end
    end

    // ----------------------------------------
    // shared prescaler
    // ----------------------------------------
    // counted as a synchronous stand-in for the ripple chain; tapping one bit
    // keeps the output symmetric, so each half still meets the sample rule
    assign pre_clear = option.prescaler_assign_bit ? watchdog_clear_instr
                                                   : count_wr;

    always_comb begin
        next_pre_cnt = pre_cnt;
        if (pre_clear) begin
            next_pre_cnt = 8'h00;
        end else if (option.prescaler_assign_bit) begin
            if (watchdog_tick) begin
                next_pre_cnt = pre_cnt + 8'h01;
            end
        end else if (src_rise) begin
            next_pre_cnt = pre_cnt + 8'h01;
        end
    end

    // no read path reaches this counter; a write only clears it, through pre_clear
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_cnt <= 8'h00;
        end else begin
            pre_cnt <= next_pre_cnt;
        end
    end

    // bit n toggles every 2^n edges, so ratio field 0 gives 1:2 .. 7 gives 1:256
    assign timer_level = option.prescaler_assign_bit ? src_level
                                                     : pre_cnt[option.prescale_ratio_field];

    // ----------------------------------------
    // resynchronisation on Q2 and Q4
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 1'b1;
            sync_b <= 1'b1;
        end else if (sample_en) begin
            sync_a <= timer_level;
            sync_b <= sync_a;
        end
    end

    // increment lands one sample after the edge was caught, never on it
    assign t0_inc = sample_en && sync_a && !sync_b;
    assign t0_roll = t0_inc && (timer0_count == 8'hff);

    // ----------------------------------------
    // watchdog postscaler
    // ----------------------------------------
    // undivided when the prescaler belongs to the timer
    assign wdt_hit = watchdog_tick && !watchdog_clear_instr &&
        (!option.prescaler_assign_bit ||
         (((pre_cnt + 8'h01) & ratio_mask(option.prescale_ratio_field)) == 8'h00));

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            watchdog_timeout <= 1'b0;
        end else begin
            watchdog_timeout <= wdt_hit;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    // a software write wins over a coincident increment
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer0_count <= `TMZ_RST_COUNT;
        end else if (count_wr) begin
            timer0_count <= reg_req.wdata;
        end else if (t0_inc) begin
            timer0_count <= timer0_count + 8'h01;
        end
    end

    // overflow set wins over a clearing write in the same cycle
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            interrupt_control <= `TMZ_RST_INTC;
        end else if (intc_wr || t0_roll) begin
            interrupt_control <= (intc_wr ? reg_req.wdata : interrupt_control) |
                                 (8'(t0_roll) << `TMZ_INTC_FLAG_BIT);
        end
    end

    // takes effect on the next edge whatever the timer is doing
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            option <= tmz_option_type'(`TMZ_RST_OPTION);
        end else if (option_wr) begin
            option <= tmz_option_type'(reg_req.wdata);
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            porta_direction <= `TMZ_RST_DIR;
        end else if (reg_req.wr && (wr_sel == TMZ_SEL_DIR)) begin
            porta_direction <= reg_req.wdata[5:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_select(reg_req.addr))
                TMZ_SEL_COUNT: reg_rdata <= timer0_count;
                TMZ_SEL_INTC: reg_rdata <= interrupt_control;
                TMZ_SEL_OPTION: reg_rdata <= option;
                TMZ_SEL_DIR: reg_rdata <= {2'h0, porta_direction};
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= interrupt_control[`TMZ_INTC_FLAG_BIT] &&
                         interrupt_control[`TMZ_INTC_IRQ_EN_BIT];
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    property p_sample_phase;
        @(posedge clk) disable iff (!reset_n)
        !sample_en |=> $stable(sync_a);
    endproperty
    a_sample_phase: assert property (p_sample_phase)
        else $error("sync stage changed outside Q2 or Q4");

    property p_pre_count;
        @(posedge clk) disable iff (!reset_n)
        !option.prescaler_assign_bit && src_rise && !count_wr && !option_wr
        |=> pre_cnt == $past(pre_cnt) + 8'h01;
    endproperty
    a_pre_count: assert property (p_pre_count)
        else $error("prescaler missed a source edge");

    property p_inc_delay;
        @(posedge clk) disable iff (!reset_n)
        option.prescaler_assign_bit && option.clock_source_select && $rose(src_level)
        && !sync_a && !sync_b && !option_wr ##1 !option_wr [*4]
        |-> $past(t0_inc, 1) || $past(t0_inc, 2) || $past(t0_inc, 3) || $past(t0_inc, 4);
    endproperty
    a_inc_delay: assert property (p_inc_delay)
        else $error("timer did not step within four clocks of the pin edge");

    property p_wdt_undivided;
        @(posedge clk) disable iff (!reset_n)
        !option.prescaler_assign_bit && watchdog_tick && !watchdog_clear_instr
        |=> watchdog_timeout;
    endproperty
    a_wdt_undivided: assert property (p_wdt_undivided)
        else $error("watchdog divided while prescaler belongs to timer");

    property p_timer_holds;
        @(posedge clk) disable iff (!reset_n)
        option.prescaler_assign_bit && !watchdog_tick && !pre_clear |=> $stable(pre_cnt);
    endproperty
    a_timer_holds: assert property (p_timer_holds)
        else $error("prescaler moved without a watchdog tick");

    property p_wdt_ratio_one;
        @(posedge clk) disable iff (!reset_n)
        option.prescaler_assign_bit && option.prescale_ratio_field == 3'h0
        && watchdog_tick && !watchdog_clear_instr |=> watchdog_timeout;
    endproperty
    a_wdt_ratio_one: assert property (p_wdt_ratio_one)
        else $error("watchdog ratio 1:1 did not time out");

    property p_count_clear;
        @(posedge clk) disable iff (!reset_n)
        count_wr && !option.prescaler_assign_bit |=> pre_cnt == 8'h00;
    endproperty
    a_count_clear: assert property (p_count_clear)
        else $error("count write left prescaler uncleared");

    property p_wdt_clear;
        @(posedge clk) disable iff (!reset_n)
        watchdog_clear_instr && option.prescaler_assign_bit |=> pre_cnt == 8'h00;
    endproperty
    a_wdt_clear: assert property (p_wdt_clear)
        else $error("watchdog clear left prescaler uncleared");

    property p_option_kept;
        @(posedge clk) disable iff (!reset_n)
        count_wr && !option_wr |=> $stable(option);
    endproperty
    a_option_kept: assert property (p_option_kept)
        else $error("count write disturbed the option setting");

    property p_option_live;
        @(posedge clk) disable iff (!reset_n)
        option_wr |=> option == $past(reg_req.wdata);
    endproperty
    a_option_live: assert property (p_option_live)
        else $error("option write not taken");

    property p_overflow;
        @(posedge clk) disable iff (!reset_n)
        t0_roll && !count_wr |=> interrupt_control[`TMZ_INTC_FLAG_BIT] && timer0_count == 8'h00;
    endproperty
    a_overflow: assert property (p_overflow)
        else $error("rollover did not set the overflow flag");

    c_overflow: cover property (@(posedge clk) disable iff (!reset_n) t0_roll);
    c_wdt_div: cover property (@(posedge clk) disable iff (!reset_n)
        wdt_hit && option.prescaler_assign_bit && option.prescale_ratio_field != 3'h0);
    c_ext_inc: cover property (@(posedge clk) disable iff (!reset_n)
        t0_inc && option.clock_source_select && !option.prescaler_assign_bit);
    c_flag_race: cover property (@(posedge clk) disable iff (!reset_n) t0_roll && intc_wr);

endmodule

// ---- tmz_timer0_tb_top.sv ----
// Purpose: self-checking bench for the shared prescaler timer
// Assumes: read data valid the cycle after the read strobe
// Notes: time-out pulses are counted by a monitor, not sampled at one edge
`timescale 1ns/1ps
`include "tmz_params.svh"

module tmz_timer0_tb_top;
    import tmz_pkg::*;
    logic clk;
    logic reset_n;
    tmz_reg_req_type reg_req;
    logic [7:0] reg_rdata;
    logic pin;
    logic wd_clear;
    logic wd_tick;
    logic watchdog_timeout;
    logic timer_irq;
    logic [5:0] porta_direction;
    logic [7:0] rd;
    int fails = 0;
    int checks = 0;
    int wd_n = 0;
    int base;

    always #5 clk = ~clk;

    tmz_timer0 tmz_timer0_inst (
        .clk(clk), .reset_n(reset_n), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .timer_ext_clock_pin(pin), .watchdog_clear_instr(wd_clear),
        .watchdog_tick(wd_tick), .watchdog_timeout(watchdog_timeout),
        .timer_irq(timer_irq), .porta_direction(porta_direction)
    );

    tmz_pin_source tmz_pin_source_inst (.clk(clk), .pin(pin));

    always @(posedge clk) begin
        if (watchdog_timeout === 1'b1) begin
            wd_n <= wd_n + 1;
        end
    end

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        reg_req.wr <= 1'b0;
    endtask

    task automatic rdr(input logic [8:0] a);
        @(posedge clk);
        reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clk);
        reg_req.rd <= 1'b0;
        @(posedge clk);
        #1 rd = reg_rdata;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic rcheck(input string name, input logic [8:0] a, input logic [7:0] exp);
        rdr(a);
        check(name, rd, exp);
    endtask

    task automatic pulse_in(input bit clr);
        @(posedge clk);
        if (clr) wd_clear <= 1'b1;
        else wd_tick <= 1'b1;
        @(posedge clk);
        wd_clear <= 1'b0;
        wd_tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic conclude();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        fails++;
        conclude();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        reset_n = 1'b0;
        reg_req = '0;
        wd_clear = 1'b0;
        wd_tick = 1'b0;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        rcheck("count", `TMZ_ADDR_COUNT_A, `TMZ_RST_COUNT);
        rcheck("intc", `TMZ_ADDR_INTC_D, `TMZ_RST_INTC);
        rcheck("option", `TMZ_ADDR_OPT_B, `TMZ_RST_OPTION);
        rcheck("dir", `TMZ_ADDR_DIR, {2'b00, `TMZ_RST_DIR});
        check("dir_pins", {2'b00, porta_direction}, 8'h3f);
        rcheck("unmapped", 9'h002, 8'h00);
        wr(`TMZ_ADDR_DIR, 8'h15);
        rcheck("dir_wr", `TMZ_ADDR_DIR, 8'h15);
        // watchdog holds the counter at 1:2
        wr(`TMZ_ADDR_OPT_A, 8'hc9);
        pulse_in(1'b1);
        base = wd_n;
        pulse_in(1'b0);
        check("wd_div_1", 8'(wd_n - base), 8'h00);
        pulse_in(1'b0);
        check("wd_div_2", 8'(wd_n - base), 8'h01);
        pulse_in(1'b0);
        pulse_in(1'b1);
        pulse_in(1'b0);
        check("wd_clear", 8'(wd_n - base), 8'h01);
        // back to the timer: clear first, then select
        pulse_in(1'b1);
        wr(`TMZ_ADDR_OPT_B, 8'he0);
        base = wd_n;
        pulse_in(1'b0);
        pulse_in(1'b0);
        check("wd_undiv", 8'(wd_n - base), 8'h02);
        wr(`TMZ_ADDR_COUNT_A, 8'h00);
        tmz_pin_source_inst.pulses(6);
        rcheck("div2", `TMZ_ADDR_COUNT_B, 8'h03);
        // clear the prescaler before the ratio moves, so the new tap starts low
        wr(`TMZ_ADDR_COUNT_B, 8'h00);
        wr(`TMZ_ADDR_OPT_A, 8'he1);
        tmz_pin_source_inst.pulses(8);
        rcheck("div4", `TMZ_ADDR_COUNT_A, 8'h02);
        // partial prescale is dropped by a count write
        wr(`TMZ_ADDR_COUNT_A, 8'h00);
        tmz_pin_source_inst.pulses(1);
        wr(`TMZ_ADDR_COUNT_A, 8'h00);
        tmz_pin_source_inst.pulses(1);
        rcheck("pre_clr", `TMZ_ADDR_COUNT_A, 8'h00);
        tmz_pin_source_inst.pulses(3);
        rcheck("pre_clr2", `TMZ_ADDR_COUNT_A, 8'h01);
        rcheck("opt_kept", `TMZ_ADDR_OPT_A, 8'he1);
        // timer to watchdog with final 1:1, ratio is already non 1:1
        wr(`TMZ_ADDR_COUNT_A, 8'h00);
        wr(`TMZ_ADDR_OPT_A, 8'he9);
        pulse_in(1'b1);
        wr(`TMZ_ADDR_OPT_A, 8'he8);
        base = wd_n;
        pulse_in(1'b0);
        check("wd_1to1", 8'(wd_n - base), 8'h01);
        wr(`TMZ_ADDR_COUNT_A, 8'h00);
        tmz_pin_source_inst.pulses(5);
        rcheck("rise_direct", `TMZ_ADDR_COUNT_A, 8'h05);
        wr(`TMZ_ADDR_OPT_A, 8'hf8);
        // flipping the edge select is itself an edge; let it count before clearing
        repeat (8) @(posedge clk);
        wr(`TMZ_ADDR_COUNT_A, 8'h00);
        tmz_pin_source_inst.pulses(5);
        rcheck("fall_direct", `TMZ_ADDR_COUNT_A, 8'h05);
        // instruction clock rolls the count over
        wr(`TMZ_ADDR_OPT_A, 8'hc8);
        wr(`TMZ_ADDR_COUNT_A, 8'hff);
        repeat (16) @(posedge clk);
        rcheck("ovf_flag", `TMZ_ADDR_INTC_A, 8'h04);
        check("irq_masked", {7'h00, timer_irq}, 8'h00);
        wr(`TMZ_ADDR_INTC_B, 8'h24);
        repeat (2) @(posedge clk);
        check("irq_on", {7'h00, timer_irq}, 8'h01);
        wr(`TMZ_ADDR_INTC_C, 8'h20);
        repeat (2) @(posedge clk);
        check("irq_off", {7'h00, timer_irq}, 8'h00);
        conclude();
    end
endmodule
